// ### hw/sdf_top.sv
// Purpose: Sinc3 decimation filter for a sigma-delta modulator bitstream
// Assumes: mod_bit is valid in each cycle where mod_strobe is high
// Notes:   Register bus reads return data one cycle after the strobe
//
// Contract
// - The modulator strobe runs at the master clock divided by 128 at every gain.
// - Higher gain is made by more input samples per modulator cycle and capacitor scaling.
// - The input sampling strobe is clock/64 at gain 1, x2, x4, and x8 for gains 8 to 128.
// - The reference is sampled at clock/64 whatever the gain.
// - The polarity bit changes only output coding, never input conditioning.
// - The datapath holds 5% overrange without saturating inside.
// - The filter is three cascaded moving sums, each normalised by 1/N.
// - The phase response is linear, -3*pi*(N-1)*f/fs.
// - Two rate-select bits set N; the update rate equals the first notch.
// - Notches fall at every multiple of the first notch, deeper than 100 dB.
// - After an unsynchronised step words may be invalid for up to four periods.
// - After a synchronised restart, settled data comes after exactly three periods.
// - One output word is produced per decimation period.
// - Arithmetic runs at 33 bits and delivers a 16-bit word.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
module sdf_top
    import sdf_pkg::*;
(
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       srst,
    // Register port
    input  wire logic [sdf_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic [31:0]                     reg_rdata,
    // Modulator side
    input  wire logic                       mod_bit,
    output logic                            mod_strobe,
    output logic                            input_sample_strobe,
    output logic                            ref_sample_strobe,
    output logic [sdf_pkg::GAIN_W-1:0]      reference_sampling_capacitor_sel,
    output logic [3:0]                      input_samples_per_cycle,
    // Filter sync pin
    input  wire logic                       filter_sync,
    // Output words
    output logic [sdf_pkg::OUT_W-1:0]       data_word,
    output logic                            data_ready,
    output logic                            data_settled
);
    import sdf_pkg::*;

    // ==================================================================
    // State shared by the strobe generator, read mux and datapath
    logic [1:0]        rate_r,    rate_nxt;
    logic [GAIN_W-1:0] gain_r,    gain_nxt;
    logic              bipolar_r, bipolar_nxt;
    logic              ready_r,   ready_nxt;
    logic [31:0]       rdata_r,   rdata_nxt;
    logic              cfg_wr;
    logic              restart;
    logic              pend_r,    pend_nxt;
    logic [OUT_W-1:0]  word_r,    word_nxt;
    logic              settled_max;

    // ==================================================================
    // Strobe generator
    sdf_clkgen u_clkgen (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .gain_code (gain_r),
        .mod_stb   (mod_strobe),
        .in_stb    (input_sample_strobe),
        .ref_stb   (ref_sample_strobe)
    );

    // ==================================================================
    // Register port

    // Config writes restart the filter so no word mixes two settings
    assign cfg_wr  = reg_wr && (reg_addr == REG_CLOCK || reg_addr == REG_SETUP);
    assign restart = filter_sync || cfg_wr;

    always_comb begin
        rate_nxt    = rate_r;
        gain_nxt    = gain_r;
        bipolar_nxt = bipolar_r;
        rdata_nxt   = 32'h0;
        ready_nxt   = ready_r;
        if (reg_wr && reg_addr == REG_CLOCK) begin
            rate_nxt = {reg_wdata[CLK_RATE_HI], reg_wdata[CLK_RATE_LO]};
        end
        if (reg_wr && reg_addr == REG_SETUP) begin
            gain_nxt    = reg_wdata[SETUP_GAIN +: GAIN_W];
            bipolar_nxt = reg_wdata[SETUP_POL];
        end
        if (reg_rd) begin
            unique case (reg_addr)
                REG_CLOCK:  rdata_nxt = {30'h0, rate_r};
                REG_SETUP:  rdata_nxt = {28'h0, bipolar_r, gain_r};
                REG_DATA:   rdata_nxt = {16'h0, word_r};
                REG_STATUS: rdata_nxt = {28'h0, filter_sync, settled_max,
                                         data_settled, ready_r};
                default:    rdata_nxt = 32'h0;
            endcase
        end
        // New word beats a clearing read in the same cycle
        if (reg_rd && reg_addr == REG_DATA) begin
            ready_nxt = 1'b0;
        end
        if (pend_r && !restart) begin
            ready_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rate_r    <= RATE_RST;
            gain_r    <= GAIN_RST;
            bipolar_r <= POL_RST;
            rdata_r   <= 32'h0;
            ready_r   <= 1'b0;
        end else begin
            rate_r    <= rate_nxt;
            gain_r    <= gain_nxt;
            bipolar_r <= bipolar_nxt;
            rdata_r   <= rdata_nxt;
            ready_r   <= ready_nxt;
        end
    end

    assign reg_rdata                        = rdata_r;
    // Capacitor ratio and samples per cycle follow the gain code only
    assign reference_sampling_capacitor_sel = gain_r;
    assign input_samples_per_cycle          = 4'h1 << sdf_gain_shift(gain_r);

    // ==================================================================
    // Integrators, decimation counter and combs
    logic signed [ACC_W-1:0] int1_r, int1_nxt, int2_r, int2_nxt, int3_r, int3_nxt;
    logic signed [ACC_W-1:0] dl1_r, dl1_nxt, dl2_r, dl2_nxt, dl3_r, dl3_nxt;
    logic signed [ACC_W-1:0] c1, c2, c3;
    logic signed [ACC_W-1:0] sum_r, sum_nxt;
    logic [DEC_W-1:0]        dec_cnt_r, dec_cnt_nxt;
    logic                    dec_hit;

    // Wrapping modular sums are exact as long as N^3 fits in ACC_W bits
    always_comb begin
        int1_nxt    = int1_r;
        int2_nxt    = int2_r;
        int3_nxt    = int3_r;
        dl1_nxt     = dl1_r;
        dl2_nxt     = dl2_r;
        dl3_nxt     = dl3_r;
        sum_nxt     = sum_r;
        dec_cnt_nxt = dec_cnt_r;
        pend_nxt    = 1'b0;
        dec_hit     = 1'b0;
        c1          = '0;
        c2          = '0;
        c3          = '0;
        if (mod_strobe) begin
            int1_nxt = int1_r + (mod_bit ? ACC_ONE : ACC_MONE);
            int2_nxt = int2_r + int1_nxt;
            int3_nxt = int3_r + int2_nxt;
            dec_hit  = (dec_cnt_r == sdf_dec_ratio(rate_r) - 9'h001);
            dec_cnt_nxt = dec_hit ? '0 : dec_cnt_r + 9'h001;
        end
        if (dec_hit) begin
            // Equal-length moving sums keep the phase linear and notches periodic
            c1       = int3_nxt - dl1_r;
            c2       = c1 - dl2_r;
            c3       = c2 - dl3_r;
            dl1_nxt  = int3_nxt;
            dl2_nxt  = c1;
            dl3_nxt  = c2;
            sum_nxt  = c3;
            pend_nxt = 1'b1;
        end
        if (restart) begin
            int1_nxt    = '0;
            int2_nxt    = '0;
            int3_nxt    = '0;
            dl1_nxt     = '0;
            dl2_nxt     = '0;
            dl3_nxt     = '0;
            sum_nxt     = '0;
            dec_cnt_nxt = '0;
            pend_nxt    = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            int1_r    <= '0;
            int2_r    <= '0;
            int3_r    <= '0;
            dl1_r     <= '0;
            dl2_r     <= '0;
            dl3_r     <= '0;
            sum_r     <= '0;
            dec_cnt_r <= '0;
            pend_r    <= 1'b0;
        end else begin
            int1_r    <= int1_nxt;
            int2_r    <= int2_nxt;
            int3_r    <= int3_nxt;
            dl1_r     <= dl1_nxt;
            dl2_r     <= dl2_nxt;
            dl3_r     <= dl3_nxt;
            sum_r     <= sum_nxt;
            dec_cnt_r <= dec_cnt_nxt;
            pend_r    <= pend_nxt;
        end
    end

    // ==================================================================
    // Normalise, code and settle tracking
    logic signed [65:0]      prod;
    logic signed [19:0]      scaled;
    logic signed [19:0]      code;
    logic                    valid_r, valid_nxt;
    logic [2:0]              words_r, words_nxt;

    always_comb begin
        // 1/N^3 with headroom: full modulator density lands 5% past full scale
        prod      = 66'(sum_r) * 66'($signed({1'b0, sdf_recip(rate_r)}));
        scaled    = 20'(prod >>> RECIP_SHIFT);
        code      = bipolar_r ? (scaled + CODE_MID) : (scaled <<< 1);
        word_nxt  = word_r;
        valid_nxt = 1'b0;
        words_nxt = words_r;
        if (pend_r && !restart) begin
            // Clamp only at the 16-bit edge, never inside the 33-bit path
            if (code < 20'sh0) begin
                word_nxt = '0;
            end else if (code > CODE_MAX) begin
                word_nxt = '1;
            end else begin
                word_nxt = code[OUT_W-1:0];
            end
            valid_nxt = 1'b1;
            if (words_r != SETTLE_MAX_WORDS) begin
                words_nxt = words_r + 3'h1;
            end
        end
        if (restart) begin
            words_nxt = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            word_r  <= '0;
            valid_r <= 1'b0;
            words_r <= '0;
        end else begin
            word_r  <= word_nxt;
            valid_r <= valid_nxt;
            words_r <= words_nxt;
        end
    end

    assign data_word    = word_r;
    assign data_ready   = valid_r;
    // Third word after a restart covers exactly 3N fresh samples
    assign data_settled = (words_r >= SETTLE_SYNC_WORDS);
    // Unknown step time: four words guarantee a clean window
    assign settled_max  = (words_r == SETTLE_MAX_WORDS);

    // ==================================================================
    // Checks
    dec_span_a : assert property (@(posedge sys_clk) disable iff (srst)
        dec_cnt_r < sdf_dec_ratio(rate_r))
        else $error("decimation counter beyond ratio");
    word_after_dec_a : assert property (@(posedge sys_clk) disable iff (srst)
        (dec_hit && !restart ##1 !restart) |-> ##1 data_ready)
        else $error("no word two cycles after decimation");
    sync_hold_a : assert property (@(posedge sys_clk) disable iff (srst)
        filter_sync |=> (int3_r == '0 && dec_cnt_r == '0 && !data_settled && !pend_r))
        else $error("filter not held during sync");
    settle_three_a : assert property (@(posedge sys_clk) disable iff (srst)
        $rose(data_settled) |-> data_ready && words_r == SETTLE_SYNC_WORDS)
        else $error("settled flag not on third word");
    settle_clear_a : assert property (@(posedge sys_clk) disable iff (srst)
        (data_ready && words_r < SETTLE_SYNC_WORDS) |-> !data_settled && !settled_max)
        else $error("early word marked settled");
    code_zero_a : assert property (@(posedge sys_clk) disable iff (srst)
        (data_ready && sum_r == '0) |-> data_word == (bipolar_r ? 16'h8000 : 16'h0000))
        else $error("zero input not at midscale or zero code");
    ready_flag_a : assert property (@(posedge sys_clk) disable iff (srst)
        data_ready |-> ready_r)
        else $error("new word did not set the status flag");
    word_pulse_a : assert property (@(posedge sys_clk) disable iff (srst)
        data_ready |=> !data_ready)
        else $error("data ready longer than one cycle");
    restart_drop_a : assert property (@(posedge sys_clk) disable iff (srst)
        restart |=> !pend_r && !data_ready && words_r == 3'h0)
        else $error("restart did not clear the filter");
    settled_keep_a : assert property (@(posedge sys_clk) disable iff (srst)
        (data_settled && !restart) |=> data_settled)
        else $error("settled flag dropped without restart");
    cov_word_c : cover property (@(posedge sys_clk) disable iff (srst)
        data_ready && data_settled);
    cov_sync_c : cover property (@(posedge sys_clk) disable iff (srst)
        $fell(filter_sync) ##[1:1000] data_ready);
    cov_uni_c : cover property (@(posedge sys_clk) disable iff (srst)
        data_ready && !bipolar_r && data_word == 16'hffff);

endmodule : sdf_top

// ### hw/sdf_pkg.sv
// Purpose: Shared constants for the sinc3 decimation filter
// Assumes: 20 MHz master clock, modulator bit valid on the modulator strobe
// Notes:   Decimation ratios and register offsets are plain defaults
package sdf_pkg;

    // ==================================================================
    // Clock and strobe division
    localparam int unsigned SYS_CLK_HZ = 20_000_000;
    localparam int          DIV_W      = 7;
    localparam int          MOD_DIV    = 128;
    localparam int          SAMP_DIV   = 64;
    localparam int          REF_DIV    = 64;
    localparam int          GAIN_W     = 3;
    localparam int          MAX_SHIFT  = 3;
    localparam logic [6:0]  MOD_LAST   = 7'(MOD_DIV - 1);
    localparam logic [5:0]  SAMP_MASK  = 6'(SAMP_DIV - 1);
    localparam logic [5:0]  REF_LAST   = 6'(REF_DIV - 1);

    // ==================================================================
    // Datapath
    localparam int          ACC_W       = 33;
    localparam int          OUT_W       = 16;
    localparam int          DEC_W       = 9;
    localparam int          RECIP_SHIFT = 31;
    localparam int          HEADROOM_PM = 1050;
    localparam int          FS_CODE     = 32768;
    localparam int          DEC_N0      = 384;
    localparam int          DEC_N1      = 320;
    localparam int          DEC_N2      = 80;
    localparam int          DEC_N3      = 40;
    localparam logic [ACC_W-1:0] ACC_ONE  = 33'h000000001;
    localparam logic [ACC_W-1:0] ACC_MONE = 33'h1ffffffff;
    localparam logic signed [19:0] CODE_MID = 20'sh08000;
    localparam logic signed [19:0] CODE_MAX = 20'sh0ffff;

    // Gain of N^-3 with 5% headroom, fixed point with RECIP_SHIFT bits
    function automatic longint unsigned sdf_recip_calc(input int n);
        longint unsigned num;
        num = longint'(FS_CODE) * longint'(HEADROOM_PM);
        return (num << RECIP_SHIFT) / (longint'(n) * n * n * 1000);
    endfunction : sdf_recip_calc

    localparam logic [31:0] RECIP0 = 32'(sdf_recip_calc(DEC_N0));
    localparam logic [31:0] RECIP1 = 32'(sdf_recip_calc(DEC_N1));
    localparam logic [31:0] RECIP2 = 32'(sdf_recip_calc(DEC_N2));
    localparam logic [31:0] RECIP3 = 32'(sdf_recip_calc(DEC_N3));

    // ==================================================================
    // Settling
    localparam logic [2:0] SETTLE_SYNC_WORDS = 3'h3;
    localparam logic [2:0] SETTLE_MAX_WORDS  = 3'h4;

    // ==================================================================
    // Register map
    localparam int         ADDR_W      = 4;
    localparam logic [3:0] REG_CLOCK   = 4'h0;
    localparam logic [3:0] REG_SETUP   = 4'h4;
    localparam logic [3:0] REG_DATA    = 4'h8;
    localparam logic [3:0] REG_STATUS  = 4'hc;
    localparam int         CLK_RATE_LO = 0;
    localparam int         CLK_RATE_HI = 1;
    localparam int         SETUP_GAIN  = 0;
    localparam int         SETUP_POL   = 3;
    localparam logic [1:0] RATE_RST    = 2'h0;
    localparam logic [2:0] GAIN_RST    = 3'h0;
    localparam logic       POL_RST     = 1'b1;

    // ==================================================================
    // Rate select decode
    function automatic logic [DEC_W-1:0] sdf_dec_ratio(input logic [1:0] sel);
        unique case (sel)
            2'h0: return DEC_W'(DEC_N0);
            2'h1: return DEC_W'(DEC_N1);
            2'h2: return DEC_W'(DEC_N2);
            2'h3: return DEC_W'(DEC_N3);
        endcase
    endfunction : sdf_dec_ratio

    function automatic logic [31:0] sdf_recip(input logic [1:0] sel);
        unique case (sel)
            2'h0: return RECIP0;
            2'h1: return RECIP1;
            2'h2: return RECIP2;
            2'h3: return RECIP3;
        endcase
    endfunction : sdf_recip

    function automatic logic [1:0] sdf_gain_shift(input logic [2:0] gain);
        return (gain > 3'(MAX_SHIFT)) ? 2'(MAX_SHIFT) : gain[1:0];
    endfunction : sdf_gain_shift

endpackage : sdf_pkg

// ### hw/sdf_clkgen.sv
// Purpose: Modulator, input sampling and reference sampling strobes
// Assumes: sys_clk is the master clock
// Notes:   All strobes share one free counter so they stay phase locked
`timescale 1ns/1ps
module sdf_clkgen
    import sdf_pkg::*;
(
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     srst,
    // Gain code
    input  wire logic [sdf_pkg::GAIN_W-1:0] gain_code,
    // Strobes
    output logic                          mod_stb,
    output logic                          in_stb,
    output logic                          ref_stb
);
    import sdf_pkg::*;

    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] cnt_nxt;
    logic [5:0]       mask;

    // ==================================================================
    // Divider
    always_comb begin
        cnt_nxt = cnt_r + 7'h01;
        mask    = SAMP_MASK >> sdf_gain_shift(gain_code);
        mod_stb = (cnt_r == MOD_LAST);
        ref_stb = (cnt_r[5:0] == REF_LAST);
        in_stb  = ((cnt_r[5:0] & mask) == mask);
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // ==================================================================
    // Checks
    logic [6:0] gap_r;
    logic       gap_ok_r;
    logic [6:0] in_period;
    assign in_period = 7'(SAMP_DIV) >> sdf_gain_shift(gain_code);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            gap_r    <= '0;
            gap_ok_r <= 1'b0;
        end else if (in_stb || $changed(gain_code)) begin
            gap_r    <= '0;
            gap_ok_r <= in_stb && !$changed(gain_code);
        end else begin
            gap_r    <= gap_r + 7'h01;
        end
    end

    mod_period_a : assert property (@(posedge sys_clk) disable iff (srst)
        mod_stb |=> !mod_stb ##127 mod_stb)
        else $error("modulator strobe period is not 128");
    ref_align_a : assert property (@(posedge sys_clk) disable iff (srst)
        ref_stb |-> ##64 ref_stb && (mod_stb || $past(mod_stb, 64)))
        else $error("reference strobe period is not 64");
    in_gap_a : assert property (@(posedge sys_clk) disable iff (srst)
        (in_stb && gap_ok_r && $stable(gain_code)) |-> gap_r == in_period - 7'h01)
        else $error("input strobe spacing wrong for gain");
    cov_gain8_c : cover property (@(posedge sys_clk) disable iff (srst)
        in_stb && gain_code == 3'h7 ##8 in_stb);

endmodule : sdf_clkgen

// ### testbench/sdf_mod_model.sv
// Purpose: Modulator bitstream source facing the filter
// Assumes: mod_bit is taken on edges where mod_strobe is high
// Notes:   Pattern 0 all zeros, 1 all ones, 2 alternating
`timescale 1ns/1ps
module sdf_mod_model (
    // Clock
    input  wire logic       sys_clk,
    // Control
    input  wire logic [1:0] pattern,
    input  wire logic       mod_strobe,
    // Bitstream
    output logic            mod_bit
);
    // ==================================================================
    // Bit source
    logic toggle_r;
    initial toggle_r = 1'b0;
    // Bit moves only after a taken edge, so each strobe sees a clean level
    always @(posedge sys_clk) begin
        if (mod_strobe) begin
            toggle_r <= ~toggle_r;
        end
    end
    // Full density drives past nominal full scale into the headroom
    assign mod_bit = (pattern == 2'h2) ? toggle_r : pattern[0];
endmodule : sdf_mod_model

// ### testbench/sdf_tb.sv
// Purpose: Self-checking bench for the sinc3 decimation filter
// Assumes: 20 MHz clock, register reads answer one cycle later
// Notes:   Fastest rate codes keep the run short
`timescale 1ns/1ps
module testbench;
    import sdf_pkg::*;
    // ==================================================================
    // Signals
    logic        sys_clk, srst, reg_wr, reg_rd, mod_bit, filter_sync;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_val;
    logic        mod_strobe, input_sample_strobe, ref_sample_strobe;
    logic [2:0]  cap_sel;
    logic [3:0]  spc;
    logic [15:0] data_word;
    logic        data_ready, data_settled;
    logic [1:0]  pattern;
    wire  [2:0]  strb = {ref_sample_strobe, input_sample_strobe, mod_strobe};
    int          err_total, cmp_count, cyc, n, cnt;
    int          codes[5] = '{0, 1, 2, 3, 7};

    sdf_top dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mod_bit(mod_bit), .mod_strobe(mod_strobe),
        .input_sample_strobe(input_sample_strobe),
        .ref_sample_strobe(ref_sample_strobe),
        .reference_sampling_capacitor_sel(cap_sel),
        .input_samples_per_cycle(spc), .filter_sync(filter_sync),
        .data_word(data_word), .data_ready(data_ready), .data_settled(data_settled));
    sdf_mod_model partner (.sys_clk(sys_clk), .pattern(pattern),
        .mod_strobe(mod_strobe), .mod_bit(mod_bit));

    // ==================================================================
    // Clock and timeout
    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_total++;
            end_sim();
        end
    end

    // ==================================================================
    // Tasks
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    // Cycles from the next rising strobe to the one after it
    task automatic gap(input int idx, output int g);
        int k;
        k = 0;
        do begin @(posedge sys_clk); #1; k++; end while (strb[idx] !== 1'b1 && k < 300);
        g = 0;
        do begin @(posedge sys_clk); #1; g++; end while (strb[idx] !== 1'b1 && g < 300);
    endtask : gap

    // Cycles until the next output word
    task automatic wait_rdy(output int g);
        g = 0;
        do begin @(posedge sys_clk); #1; g++; end while (data_ready !== 1'b1 && g < 40000);
    endtask : wait_rdy

    // Config write restarts the filter; third word must be settled
    task automatic conv(input logic [3:0] setup, input logic [1:0] rate,
                        input logic [1:0] pat, input int nd, input logic [15:0] exp);
        pattern <= pat;
        reg_write(REG_CLOCK, {30'h0, rate});
        reg_write(REG_SETUP, {28'h0, setup});
        for (int k = 1; k <= 3; k++) begin
            wait_rdy(cnt);
            if (k > 1) chk(32'(cnt), 32'(nd * 128));
            if (k == 2) chk(32'(data_settled), 32'h0);
        end
        chk(32'(data_settled), 32'h1);
        chk(32'(data_word), {16'h0, exp});
        reg_read(REG_DATA, rd_val);
        chk(rd_val, {16'h0, exp});
        reg_read(REG_STATUS, rd_val);
        chk(rd_val, 32'h2);
        $display("conversion rate %0d done", rate);
    endtask : conv

    // ==================================================================
    // Main sequence
    initial begin
        err_total = 0; cmp_count = 0; cyc = 0; srst = 1'b1;
        reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 32'h0;
        filter_sync = 1'b0; pattern = 2'h2;
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        reg_read(REG_CLOCK, rd_val);
        chk(rd_val, 32'h0);
        reg_read(REG_SETUP, rd_val);
        chk(rd_val, 32'h8);
        reg_read(4'h2, rd_val);
        chk(rd_val, 32'h0);
        chk({15'h0, data_settled, data_word}, 32'h0);
        $display("reset test done");
        foreach (codes[i]) begin
            reg_write(REG_SETUP, 32'(8 + codes[i]));
            n = (codes[i] > 3) ? 3 : codes[i];
            gap(1, cnt);
            chk(32'(cnt), 32'(64 >> n));
            chk({28'h0, spc}, 32'(1 << n));
            chk({29'h0, cap_sel}, 32'(codes[i]));
            gap(0, cnt);
            chk(32'(cnt), 32'h80);
            gap(2, cnt);
            chk(32'(cnt), 32'h40);
        end
        $display("strobe test done");
        // Fastest rate: without the hold a word would land inside the window
        reg_write(REG_CLOCK, 32'h3);
        @(posedge sys_clk);
        filter_sync <= 1'b1;
        n = 0;
        repeat (6000) begin @(posedge sys_clk); #1; if (data_ready === 1'b1) n++; end
        chk(32'(n), 32'h0);
        reg_read(REG_STATUS, rd_val);
        chk(rd_val, 32'h8);
        filter_sync <= 1'b0;
        $display("sync hold test done");
        conv(4'h8, 2'h3, 2'h2, DEC_N3, 16'h8000);
        // Fourth word raises the unsynchronised settle bit beside new data
        wait_rdy(cnt);
        reg_read(REG_STATUS, rd_val);
        chk(rd_val, 32'h7);
        conv(4'h0, 2'h3, 2'h2, DEC_N3, 16'h0000);
        conv(4'h8, 2'h2, 2'h1, DEC_N2, 16'hffff);
        end_sim();
    end
endmodule : testbench
